// ==== core/cfa_alarms.v ====
// clock upset and lane fifo upset alarms with an avalon-mm register slave
// assumes channel clock phase vectors and fifo pointers come from i_clk logic;
// the power-down pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "cfa_consts.vh"

// Summary of operation
// [RULE1] A phase mismatch of A and B at any half-rate compare sets the clock upset flag.
// [RULE2] The clock upset flag stays set until software writes a one; a zero does nothing.
// [RULE3] Software arms detection: link off, both channels up, link on, then clear the flag.
// [RULE4] Clock upset shows in its status bit and, with alarm select, on the cal status pin.
// [RULE5] After leaving global power-down software clears a possibly stale clock upset flag.
// [RULE6] Each lane has its own fifo upset flag, set when its fifo pointers go corrupt.
// [RULE7] Dropping then raising link enable resets the lane fifo logic, clearing an upset; the sticky lane flags here still need a software write-one.
// [RULE8] Each alarm sets its own status bit; every unmasked alarm drives the summary alarm.
// [RULE9] While link enable is low the link is in reset, serializers down and clocks gated.
// [RULE10] With alarm select set, the cal status pin goes high whenever an alarm is active.
// [RULE11] The clock comparison counts only with the link enabled and both channels powered.
module cfa_alarms #(
   parameter LANES = 8,
   parameter CW    = 4,
   parameter PW    = 4,
   parameter DEPTH = 8
) (
   input  wire                i_clk,
   input  wire                i_rst_n,
   // avalon-mm slave
   input  wire [7:0]          i_avs_address,
   input  wire                i_avs_read,
   input  wire                i_avs_write,
   input  wire [31:0]         i_avs_writedata,
   input  wire [3:0]          i_avs_byteenable,
   output wire [31:0]         o_avs_readdata,
   output wire                o_avs_waitrequest,
   // channel clock phases and lane fifo pointers
   input  wire [CW-1:0]       i_chan_a_clk_phase,
   input  wire [CW-1:0]       i_chan_b_clk_phase,
   input  wire [LANES*PW-1:0] i_lane_wr_ptr,
   input  wire [LANES*PW-1:0] i_lane_rd_ptr,
   input  wire [LANES-1:0]    i_lane_rw_err,
   // pins and link controls
   input  wire                i_powerdown_pin,
   input  wire                i_cal_done,
   output wire                o_cal_status_pin,
   output wire                o_alarm,
   output wire                o_link_rst_n,
   output wire                o_ser_powerdown,
   output wire                o_link_clk_en,
   output wire                o_chan_a_powerdown,
   output wire                o_chan_b_powerdown
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg  [7:0]       ctrl_r;
   reg  [7:0]       mask_r;
   reg              clock_upset_flag_r;
   reg              clock_upset_flag_nxt;
   reg  [LANES-1:0] lane_fifo_upset_flags_r;
   reg  [LANES-1:0] lane_fifo_upset_flags_nxt;
   reg              half_r;
   reg              pd_meta_r;
   reg              pd_sync_r;
   reg              wait_r;
   reg  [31:0]      rdata_r;
   reg  [31:0]      rdata_nxt;
   reg              alarm_r;
   reg              cal_pin_r;
   reg              link_rst_n_r;
   reg              ser_pd_r;
   reg              clk_en_r;
   reg              pd_a_r;
   reg              pd_b_r;
   wire [LANES-1:0] lane_upset;
   wire             link_enable;
   wire             global_pd;
   wire             cmp_valid;
   wire             clk_mismatch;
   wire             wr_take;
   wire             rd_take;
   wire             clr_clk;
   wire [LANES-1:0] clr_lane;
   wire             clk_alarm_on;
   wire             fifo_alarm_on;
   wire             summary;

   // ------------------------------------------------------------
   // control decode
   // ------------------------------------------------------------
   assign link_enable = ctrl_r[`CFA_CTRL_LINK_EN];
   assign global_pd   = ctrl_r[`CFA_CTRL_GPD] | pd_sync_r;

   // comparison is meaningless with a channel or the link off [RULE11]
   assign cmp_valid   = link_enable & ~ctrl_r[`CFA_CTRL_PD_A] & ~ctrl_r[`CFA_CTRL_PD_B]
                        & ~global_pd;

   // ------------------------------------------------------------
   // power-down pin synchroniser
   // ------------------------------------------------------------
   // pin is asynchronous: two flops before anything reads it
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pd_meta_r <= 1'b0;
         pd_sync_r <= 1'b0;
      end else begin
         pd_meta_r <= i_powerdown_pin;
         pd_sync_r <= pd_meta_r;
      end
   end

   // ------------------------------------------------------------
   // half-rate compare strobe
   // ------------------------------------------------------------
   // the channel clocks step at half the device clock, so compare on alternate edges
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         half_r <= 1'b0;
      end else begin
         half_r <= ~half_r;
      end
   end

   // a single half-rate cycle of disagreement is enough [RULE1]
   assign clk_mismatch = half_r & cmp_valid & (i_chan_a_clk_phase != i_chan_b_clk_phase);

   // ------------------------------------------------------------
   // lane fifo watchers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         cfa_lane_mon #(
            .PW    (PW),
            .DEPTH (DEPTH)
         ) u_mon (
            .i_clk    (i_clk),
            .i_rst_n  (i_rst_n),
            .i_en     (link_enable),              // [RULE7]
            .i_wr_ptr (i_lane_wr_ptr[g*PW +: PW]),
            .i_rd_ptr (i_lane_rd_ptr[g*PW +: PW]),
            .i_rw_err (i_lane_rw_err[g]),
            .o_upset  (lane_upset[g])             // [RULE6]
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // avalon-mm handshake
   // ------------------------------------------------------------
   // waitrequest drops for one cycle after a request is seen; the access
   // completes on the edge where the master sees it low
   assign wr_take = i_avs_write & ~wait_r;
   assign rd_take = i_avs_read & wait_r; // read data latched on the request edge

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_r <= 1'b1;
      end else if (wait_r) begin
         wait_r <= ~(i_avs_read | i_avs_write);
      end else begin
         wait_r <= 1'b1;
      end
   end

   // write-one-to-clear strobes, low byte lane only
   assign clr_clk  = wr_take & i_avs_byteenable[0] & (i_avs_address == `CFA_OFS_CLK_UPSET)
                     & i_avs_writedata[0]; // [RULE2]
   assign clr_lane = (wr_take & i_avs_byteenable[0] & (i_avs_address == `CFA_OFS_LANE_ALM))
                     ? i_avs_writedata[LANES-1:0] : {LANES{1'b0}};

   // ------------------------------------------------------------
   // control and mask registers
   // ------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= `CFA_CTRL_RST;
         mask_r <= `CFA_MASK_RST;
      end else if (wr_take & i_avs_byteenable[0]) begin
         if (i_avs_address == `CFA_OFS_CTRL) begin
            ctrl_r <= {3'h0, i_avs_writedata[4:0]};
         end
         if (i_avs_address == `CFA_OFS_MASK) begin
            mask_r <= {6'h00, i_avs_writedata[1:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // sticky alarm flags
   // ------------------------------------------------------------
   // a set arriving with the clear wins, so no event is lost
   always @* begin
      clock_upset_flag_nxt      = (clock_upset_flag_r & ~clr_clk) | clk_mismatch; // [RULE1]
      lane_fifo_upset_flags_nxt = (lane_fifo_upset_flags_r & ~clr_lane) | lane_upset; // [RULE6]
   end

   // flags are not cleared by link enable; only software clears them
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clock_upset_flag_r      <= 1'b0;
         lane_fifo_upset_flags_r <= {LANES{1'b0}};
      end else begin
         clock_upset_flag_r      <= clock_upset_flag_nxt;
         lane_fifo_upset_flags_r <= lane_fifo_upset_flags_nxt;
      end
   end

   // ------------------------------------------------------------
   // summary alarm and pin
   // ------------------------------------------------------------
   assign clk_alarm_on  = clock_upset_flag_r & ~mask_r[`CFA_MASK_CLK];     // [RULE8]
   assign fifo_alarm_on = (|lane_fifo_upset_flags_r) & ~mask_r[`CFA_MASK_FIFO]; // [RULE8]
   assign summary       = clk_alarm_on | fifo_alarm_on;

   // pin shows the summary alarm or the calibration status by select
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm_r   <= 1'b0;
         cal_pin_r <= 1'b0;
      end else begin
         alarm_r   <= summary;
         cal_pin_r <= ctrl_r[`CFA_CTRL_CAL_SEL] ? summary : i_cal_done; // [RULE4] [RULE10]
      end
   end

   // ------------------------------------------------------------
   // link section controls
   // ------------------------------------------------------------
   // link off: reset held, serializers down, section clocks gated
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         link_rst_n_r <= 1'b0;
         ser_pd_r     <= 1'b1;
         clk_en_r     <= 1'b0;
         pd_a_r       <= 1'b0;
         pd_b_r       <= 1'b0;
      end else begin
         link_rst_n_r <= link_enable & ~global_pd;  // [RULE9]
         ser_pd_r     <= ~link_enable | global_pd;  // [RULE9]
         clk_en_r     <= link_enable & ~global_pd;  // [RULE9]
         pd_a_r       <= ctrl_r[`CFA_CTRL_PD_A] | global_pd;
         pd_b_r       <= ctrl_r[`CFA_CTRL_PD_B] | global_pd;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // unmapped addresses read as zero; reserved bits read as zero
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (i_avs_address)
         `CFA_OFS_CTRL: begin
            rdata_nxt[7:0] = ctrl_r;
         end
         `CFA_OFS_CLK_UPSET: begin
            rdata_nxt[0] = clock_upset_flag_r; // [RULE4]
         end
         `CFA_OFS_LANE_ALM: begin
            rdata_nxt[LANES-1:0] = lane_fifo_upset_flags_r;
         end
         `CFA_OFS_MASK: begin
            rdata_nxt[7:0] = mask_r;
         end
         `CFA_OFS_SUMMARY: begin
            rdata_nxt[0] = summary; // [RULE8]
         end
         `CFA_OFS_STATE: begin
            rdata_nxt[`CFA_ST_LINK_ON]   = link_rst_n_r;
            rdata_nxt[`CFA_ST_CMP_VALID] = cmp_valid;
            rdata_nxt[`CFA_ST_PWR_DOWN]  = global_pd;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // data captured on the edge that drops waitrequest, held until next answer
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_take) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_avs_readdata     = rdata_r;
   assign o_avs_waitrequest  = wait_r;
   assign o_alarm            = alarm_r;
   assign o_cal_status_pin   = cal_pin_r;
   assign o_link_rst_n       = link_rst_n_r;
   assign o_ser_powerdown    = ser_pd_r;
   assign o_link_clk_en      = clk_en_r;
   assign o_chan_a_powerdown = pd_a_r;
   assign o_chan_b_powerdown = pd_b_r;

endmodule // cfa_alarms

// ==== core/cfa_consts.vh ====
// constants for the clock and lane fifo upset alarm block
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef CFA_CONSTS_VH
`define CFA_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CFA_OFS_CTRL      8'h00
`define CFA_OFS_CLK_UPSET 8'h04
`define CFA_OFS_LANE_ALM  8'h08
`define CFA_OFS_MASK      8'h0c
`define CFA_OFS_SUMMARY   8'h10
`define CFA_OFS_STATE     8'h14

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CFA_CTRL_LINK_EN  0
`define CFA_CTRL_PD_A     1
`define CFA_CTRL_PD_B     2
`define CFA_CTRL_GPD      3
`define CFA_CTRL_CAL_SEL  4
`define CFA_CTRL_RST      8'h00

// ------------------------------------------------------------
// mask, state fields and reset values
// ------------------------------------------------------------
`define CFA_MASK_CLK      0
`define CFA_MASK_FIFO     1
`define CFA_MASK_RST      8'h00
`define CFA_ST_LINK_ON    0
`define CFA_ST_CMP_VALID  1
`define CFA_ST_PWR_DOWN   2

`endif

// ==== core/cfa_lane_mon.v ====
// one lane's synchronizing fifo pointer watcher
// assumes pointers carry one extra wrap bit and arrive on i_clk
`timescale 1ns/1ps

module cfa_lane_mon #(
   parameter PW    = 4,
   parameter DEPTH = 8
) (
   input  wire          i_clk,
   input  wire          i_rst_n,
   input  wire          i_en,
   input  wire [PW-1:0] i_wr_ptr,
   input  wire [PW-1:0] i_rd_ptr,
   input  wire          i_rw_err,
   output wire          o_upset
);

   // ------------------------------------------------------------
   // occupancy check
   // ------------------------------------------------------------
   localparam [PW-1:0] DEPTH_P = DEPTH[PW-1:0];

   wire [PW-1:0] fill;
   reg           armed_r;
   reg           upset_r;

   assign fill    = i_wr_ptr - i_rd_ptr;
   assign o_upset = upset_r;

   // first cycle after enable only arms: pointers may still settle
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_r <= 1'b0;
         upset_r <= 1'b0;
      end else if (!i_en) begin
         armed_r <= 1'b0; // link off resets the fifo watcher [RULE7]
         upset_r <= 1'b0;
      end else begin
         armed_r <= 1'b1;
         upset_r <= armed_r & (i_rw_err | (fill > DEPTH_P)); // corrupt pointers [RULE6]
      end
   end

endmodule // cfa_lane_mon

// ==== dv/cfa_alarms_checker.sv ====
// checker for cfa_alarms: bus handshake, alarm and link-control relations
// assumes one clock domain and the register layout of cfa_consts.vh
`timescale 1ns/1ps
module cfa_alarms_checker #(
   parameter CW = 4
) (
   input wire          i_clk,
   input wire          i_rst_n,
   input wire [7:0]    i_avs_address,
   input wire          i_avs_read,
   input wire          i_avs_write,
   input wire [31:0]   i_avs_writedata,
   input wire [3:0]    i_avs_byteenable,
   input wire          o_avs_waitrequest,
   input wire [CW-1:0] i_chan_a_clk_phase,
   input wire [CW-1:0] i_chan_b_clk_phase,
   input wire          i_cal_done,
   input wire          o_cal_status_pin,
   input wire          o_alarm,
   input wire          o_link_rst_n,
   input wire          o_ser_powerdown,
   input wire          o_link_clk_en,
   input wire          o_chan_a_powerdown,
   input wire          o_chan_b_powerdown
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   reg [4:0] ctrl_r;
   reg       mask_r;
   reg       up_r;
   wire acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire vld = o_link_clk_en && !o_chan_a_powerdown && !o_chan_b_powerdown && !mask_r;
   wire mis = i_chan_a_clk_phase != i_chan_b_clk_phase;
   // ----------------------------------------
   // shadow of control and mask, kept from bus writes
   // ----------------------------------------
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= 5'h00;
         mask_r <= 1'b0;
         up_r   <= 1'b0;
      end else begin
         up_r <= 1'b1; // first edge after reset still shows reset values
         if (acc && i_avs_address == 8'h00) ctrl_r <= i_avs_writedata[4:0];
         if (acc && i_avs_address == 8'h0c) mask_r <= i_avs_writedata[0];
      end
   end
   a_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_answers: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   a_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> o_avs_waitrequest) else $error("answer without request");
   a_clk_mismatch_alarm: assert property (
      (vld && mis)[*2] ##1 vld |-> ##[0:2] o_alarm) else $error("clock upset missed");
   a_alarm_sticky: assert property (
      $fell(o_alarm) |-> $past(i_avs_write && !o_avs_waitrequest, 2))
      else $error("alarm dropped without a write");
   a_cal_pin_alarm: assert property (
      up_r && $past(ctrl_r[4]) |-> o_cal_status_pin == o_alarm) else $error("pin not alarm");
   a_cal_pin_done: assert property (up_r && !$past(ctrl_r[4])
      |-> o_cal_status_pin == $past(i_cal_done)) else $error("pin not cal done");
   a_link_off_held: assert property (
      !$past(ctrl_r[0]) |-> !o_link_rst_n && !o_link_clk_en && o_ser_powerdown)
      else $error("link not held off");
   a_chan_pd_follow: assert property (
      up_r |-> ({o_chan_b_powerdown, o_chan_a_powerdown} & $past(ctrl_r[2:1]))
      == $past(ctrl_r[2:1])) else $error("channel power-down not driven");
endmodule // cfa_alarms_checker

bind cfa_alarms cfa_alarms_checker #(.CW(CW)) u_cfa_alarms_checker (.*);

// ==== dv/test_cfa_alarms.sv ====
// self-checking bench for cfa_alarms over avalon-mm
// assumes the register map of cfa_consts.vh and a 200 MHz clock
`timescale 1ns/1ps
module test_cfa_alarms;
   reg         i_clk = 1'b0;
   reg         i_rst_n = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg         rdq = 1'b0;
   reg         wrq = 1'b0;
   reg  [31:0] wdat = 32'h0;
   reg  [3:0]  be = 4'hf;
   reg  [3:0]  ph_a = 4'h0;
   reg  [3:0]  ph_b = 4'h0;
   reg  [31:0] wp = 32'h0;
   reg  [31:0] rp = 32'h0;
   reg  [7:0]  err = 8'h00;
   reg         pd_pin = 1'b0;
   reg         cal_done = 1'b0;
   reg         mism = 1'b0;
   reg  [31:0] seed = 32'h2ce2;
   reg  [31:0] exp_q[$];
   wire [31:0] rdata;
   wire        wreq, cal_pin, alarm, lrst_n, ser_pd, clk_en, pd_a, pd_b;
   integer     n_mismatch = 0;
   integer     check_count = 0;
   integer     g;

   always #2.5 i_clk = ~i_clk;

   cfa_alarms u_cfa_alarms (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
      .i_avs_read(rdq), .i_avs_write(wrq), .i_avs_writedata(wdat), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_chan_a_clk_phase(ph_a),
      .i_chan_b_clk_phase(ph_b), .i_lane_wr_ptr(wp), .i_lane_rd_ptr(rp),
      .i_lane_rw_err(err), .i_powerdown_pin(pd_pin), .i_cal_done(cal_done),
      .o_cal_status_pin(cal_pin), .o_alarm(alarm), .o_link_rst_n(lrst_n),
      .o_ser_powerdown(ser_pd), .o_link_clk_en(clk_en), .o_chan_a_powerdown(pd_a),
      .o_chan_b_powerdown(pd_b));

   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // random phases every cycle; skew makes them differ on every bit
   always @(posedge i_clk) begin
      seed <= lfsr(seed);
      ph_a <= seed[3:0];
      ph_b <= mism ? ~seed[3:0] : seed[3:0];
      cal_done <= seed[4];
   end

   task chk_rd(input [31:0] e, input [31:0] v);
      begin
         check_count = check_count + 1;
         if (v !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH readdata exp %h got %h", e, v);
         end
      end
   endtask

   task chk_pin(input [63:0] nm, input e, input v);
      begin
         check_count = check_count + 1;
         if (v !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s exp %b got %b", nm, e, v);
         end
      end
   endtask

   // read answers are matched against the oldest noted value
   always @(posedge i_clk) begin
      if (rdq && wreq === 1'b0) chk_rd(exp_q.pop_front(), rdata);
   end

   // one bus access; request held until waitrequest seen low
   // no local limit: only the watchdog ends a stuck wait
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge i_clk);
         adr <= a;
         wrq <= w;
         rdq <= !w;
         wdat <= d;
         do begin
            @(posedge i_clk);
         end while (wreq !== 1'b0);
         rdq <= 1'b0;
         wrq <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [31:0] e);
      begin
         exp_q.push_back(e);
         bus(1'b0, a, 32'h0);
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask

   task skew;
      begin
         mism <= 1'b1;
         repeat (2) @(posedge i_clk);
         mism <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask

   task conclude;
      begin
         $display("checks %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask

   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch = n_mismatch + 1;
      conclude;
   end

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (g = 0; g < 7; g = g + 1) rd(8'(g * 4 + (g == 6) * 8'h28), 32'h0);
      chk_pin("link_rst", 1'b0, lrst_n);
      chk_pin("ser_pd", 1'b1, ser_pd);
      $display("test reset done");
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h1);
      repeat (8) @(posedge i_clk);
      rd(8'h04, 32'h0);
      skew;
      rd(8'h04, 32'h1);
      rd(8'h10, 32'h1);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h1);
      be <= 4'h0; // disabled low byte must refuse the clear
      wr(8'h04, 32'h1);
      be <= 4'hf;
      rd(8'h04, 32'h1);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h0);
      $display("test clock upset done");
      wr(8'h00, 32'h11);
      skew;
      chk_pin("cal_pin", 1'b1, cal_pin);
      wr(8'h0c, 32'h1);
      repeat (2) @(posedge i_clk);
      chk_pin("alarm", 1'b0, alarm);
      rd(8'h10, 32'h0);
      rd(8'h04, 32'h1);
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h1);
      $display("test alarm pin done");
      wr(8'h00, 32'h3);
      skew;
      rd(8'h04, 32'h0);
      chk_pin("pd_a", 1'b1, pd_a);
      wr(8'h00, 32'h5);
      skew;
      rd(8'h04, 32'h0);
      chk_pin("pd_b", 1'b1, pd_b);
      wr(8'h00, 32'h9); // global power-down by mode bit
      skew;
      rd(8'h04, 32'h0);
      rd(8'h14, 32'h4);
      chk_pin("lrst_gpd", 1'b0, lrst_n);
      wr(8'h00, 32'h1);
      pd_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      skew;
      chk_pin("ser_pd", 1'b1, ser_pd);
      rd(8'h04, 32'h0);
      pd_pin <= 1'b0;
      repeat (6) @(posedge i_clk);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h0);
      rd(8'h14, 32'h3);
      $display("test compare gating done");
      wr(8'h08, 32'hff);
      for (g = 0; g < 8; g = g + 1) begin
         err <= 8'h01 << g;
         @(posedge i_clk);
         err <= 8'h00;
         repeat (3) @(posedge i_clk);
         rd(8'h08, 32'h1 << g);
         wr(8'h08, 32'h1 << g);
      end
      wp <= 32'h0098_0000; // lane 4 at depth, lane 5 one past it
      repeat (3) @(posedge i_clk);
      rd(8'h08, 32'h20);
      wr(8'h00, 32'h0);
      wp <= 32'h0;
      err <= 8'hff;
      repeat (3) @(posedge i_clk);
      err <= 8'h00;
      chk_pin("clk_en", 1'b0, clk_en);
      wr(8'h08, 32'hff);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h1);
      repeat (4) @(posedge i_clk);
      rd(8'h08, 32'h0);
      $display("test lane fifo done");
      repeat (2) @(posedge i_clk);
      conclude;
   end
endmodule // test_cfa_alarms
